//--- icwt_map.svh
// Register map, field positions, reset values and timing counts
`ifndef ICWT_MAP_SVH
`define ICWT_MAP_SVH

`define ICWT_REG_CTRL1 2'h0
`define ICWT_REG_CTRL2 2'h1
`define ICWT_REG_BUFFER 2'h2

`define ICWT_CTRL1_RESET 16'h0000
`define ICWT_CTRL1_WMASK 16'h3c67
`define ICWT_CTRL2_RESET 16'h000d
`define ICWT_CTRL2_WMASK 16'h01df

`define ICWT_IDLE_STOP_BIT 13
`define ICWT_TSEL_HI 12
`define ICWT_TSEL_LO 10
`define ICWT_ICI_HI 6
`define ICWT_ICI_LO 5
`define ICWT_OVF_BIT 4
`define ICWT_BNE_BIT 3
`define ICWT_MODE_HI 2
`define ICWT_MODE_LO 0

`define ICWT_CASCADE_BIT 8
`define ICWT_TRIG_SEL_BIT 7
`define ICWT_TRIG_STAT_BIT 6
`define ICWT_SYNC_HI 4
`define ICWT_SYNC_LO 0

`define ICWT_TSEL_SYSCLK 3'h7
`define ICWT_TSEL_TMR1 3'h4
`define ICWT_TSEL_TMR5 3'h3
`define ICWT_TSEL_TMR4 3'h2
`define ICWT_TSEL_TMR2 3'h1
`define ICWT_TSEL_TMR3 3'h0

`define ICWT_SYNC_NONE 5'h00
`define ICWT_SYNC_RSVD_TOP 5'h1f
`define ICWT_SYNC_RSVD_PAIR 4'h8
`define ICWT_SYNC_TRIG_ONLY_LO 5'h18
`define ICWT_SYNC_TRIG_ONLY_HI 5'h1c

`define ICWT_PSC4_LAST 4'h3
`define ICWT_PSC16_LAST 4'hf
`define ICWT_CNT_MAX 16'hffff

`endif

//--- icwt_pkg.sv
// Types shared by the capture unit
package icwt_pkg;
   typedef enum logic [2:0] {
      ICWT_MODE_OFF,
      ICWT_MODE_EVERY_EDGE,
      ICWT_MODE_FALL,
      ICWT_MODE_RISE,
      ICWT_MODE_RISE4,
      ICWT_MODE_RISE16,
      ICWT_MODE_DISABLED,
      ICWT_MODE_WAKE
   } icwt_capture_mode_e;

   typedef enum logic [1:0] {
      ICWT_RUN_FREE,
      ICWT_RUN_SYNC,
      ICWT_RUN_TRIG,
      ICWT_RUN_SWTRIG
   } icwt_run_e;
endpackage : icwt_pkg

//--- icwt_edge.sv
// Pin synchroniser and edge detector
`timescale 1ns/1ps
module icwt_edge (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic pin_i,
   output logic rise_o,
   output logic fall_o
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise_o = sync_reg & ~last_reg;
   assign fall_o = ~sync_reg & last_reg;
endmodule : icwt_edge

//--- icwt_fifo.sv
// Capture FIFO with valid/ready on both sides
`timescale 1ns/1ps
module icwt_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   assign in_ready_o = count_reg != DEPTH_C;
   assign out_valid_o = count_reg != '0;
   assign out_data_o = mem_reg[rd_ptr_reg];

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : icwt_fifo

//--- icwt_top.sv
// Input capture unit with dedicated counter and Avalon-MM registers
`timescale 1ns/1ps
`include "icwt_map.svh"
module icwt_top #(
   parameter int FIFO_DEPTH = 4,
   parameter bit IS_EVEN = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic capture_input_pin_i,
   input wire logic [4:0] tb_tick_i,
   input wire logic [31:0] sync_evt_i,
   input wire logic [31:0] sync_src_en_i,
   input wire logic cpu_idle_i,
   input wire logic cpu_sleep_i,
   input wire logic partner_wrap_i,
   input wire logic partner_clr_i,
   input wire logic partner_cap_i,
   output logic wrap_o,
   output logic clr_o,
   output logic cap_o,
   output logic cap_irq_o,
   output logic wake_irq_o,
   output logic buffer_not_empty_o
);
   // Register state
   logic [15:0] ctrl1_reg;
   logic [15:0] ctrl2_reg;
   logic trigger_status_reg;
   logic capture_overflow_flag_reg;
   logic [15:0] capture_counter_reg;
   logic [15:0] capture_counter_next;
   logic [3:0] psc_reg;
   logic [1:0] irq_cnt_reg;
   logic cap_irq_reg;
   logic wake_irq_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;

   // Field views
   wire idle_stop_select = ctrl1_reg[`ICWT_IDLE_STOP_BIT];
   wire [2:0] time_base_select = ctrl1_reg[`ICWT_TSEL_HI:`ICWT_TSEL_LO];
   wire [1:0] captures_per_interrupt = ctrl1_reg[`ICWT_ICI_HI:`ICWT_ICI_LO];
   wire [2:0] capture_mode_select = ctrl1_reg[`ICWT_MODE_HI:`ICWT_MODE_LO];
   wire cascade_enable = ctrl2_reg[`ICWT_CASCADE_BIT];
   wire trigger_mode_select = ctrl2_reg[`ICWT_TRIG_SEL_BIT];
   wire [4:0] sync_source_select = ctrl2_reg[`ICWT_SYNC_HI:`ICWT_SYNC_LO];
   icwt_pkg::icwt_capture_mode_e mode;
   icwt_pkg::icwt_run_e run_mode;

   // Time base selection
   function automatic logic tb_pick(input logic [2:0] sel,
                                    input logic [4:0] ticks);
      unique case (sel)
         `ICWT_TSEL_SYSCLK: tb_pick = 1'b1;
         `ICWT_TSEL_TMR1: tb_pick = ticks[0];
         `ICWT_TSEL_TMR2: tb_pick = ticks[1];
         `ICWT_TSEL_TMR3: tb_pick = ticks[2];
         `ICWT_TSEL_TMR4: tb_pick = ticks[3];
         `ICWT_TSEL_TMR5: tb_pick = ticks[4];
         default: tb_pick = 1'b0;
      endcase
   endfunction : tb_pick

   // Source codes that carry no event at all
   function automatic logic src_reserved(input logic [4:0] code);
      src_reserved = (code == `ICWT_SYNC_NONE) ||
                     (code == `ICWT_SYNC_RSVD_TOP) ||
                     (code[4:1] == `ICWT_SYNC_RSVD_PAIR);
   endfunction : src_reserved

   // Converter, comparators and charge timing may not act as sync sources
   function automatic logic src_trig_only(input logic [4:0] code);
      src_trig_only = (code >= `ICWT_SYNC_TRIG_ONLY_LO) &&
                      (code <= `ICWT_SYNC_TRIG_ONLY_HI);
   endfunction : src_trig_only

   assign mode = icwt_pkg::icwt_capture_mode_e'(capture_mode_select);

   // Operating mode from source code and trigger select
   assign run_mode = (sync_source_select == `ICWT_SYNC_NONE) ?
      (trigger_mode_select ? icwt_pkg::ICWT_RUN_SWTRIG
                           : icwt_pkg::ICWT_RUN_FREE) :
      (trigger_mode_select ? icwt_pkg::ICWT_RUN_TRIG
                           : icwt_pkg::ICWT_RUN_SYNC);

   // Pin edges
   wire pin_rise;
   wire pin_fall;

   icwt_edge u_edge (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .pin_i(capture_input_pin_i),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   // Source event decode
   wire src_evt = ~src_reserved(sync_source_select) &
                  sync_evt_i[sync_source_select];
   wire src_en = ~src_reserved(sync_source_select) &
                 sync_src_en_i[sync_source_select];
   wire sync_evt_ok = src_evt & ~src_trig_only(sync_source_select);
   wire hw_trigger = (run_mode == icwt_pkg::ICWT_RUN_TRIG) & src_evt;

   // Cascade roles
   wire casc_even = IS_EVEN & cascade_enable;
   wire casc_follow = casc_even & ~trigger_mode_select;

   wire unit_on = (mode != icwt_pkg::ICWT_MODE_OFF) &&
                  (mode != icwt_pkg::ICWT_MODE_DISABLED) &&
                  (mode != icwt_pkg::ICWT_MODE_WAKE);
   wire halted = idle_stop_select & cpu_idle_i;

   // Reasons to hold the counter at zero
   wire sync_hold = (run_mode == icwt_pkg::ICWT_RUN_SYNC) & ~src_en;
   wire trig_hold = trigger_mode_select & ~trigger_status_reg;
   wire sync_clear = (run_mode == icwt_pkg::ICWT_RUN_SYNC) &
                     sync_evt_ok;
   wire own_hold = sync_hold | trig_hold;
   wire own_clear = own_hold | sync_clear;
   wire cnt_clear = ~unit_on | (casc_follow ? partner_clr_i : own_clear);
   wire run_ok = unit_on & ~halted &
                 (casc_follow ? ~partner_clr_i : ~own_hold);

   // Counting step
   wire tick = tb_pick(time_base_select, tb_tick_i);
   wire cnt_step = ~halted &
                   (casc_even ? partner_wrap_i : tick);

   always_comb begin
      capture_counter_next = capture_counter_reg;
      if (cnt_clear) begin
         capture_counter_next = 16'h0000;
      end else if (cnt_step) begin
         capture_counter_next = capture_counter_reg + 16'h0001;
      end
   end

   assign wrap_o = cnt_step & ~cnt_clear &
                   (capture_counter_reg == `ICWT_CNT_MAX);
   assign clr_o = cnt_clear;

   // Capture event qualification
   wire psc_mode = (mode == icwt_pkg::ICWT_MODE_RISE4) ||
                   (mode == icwt_pkg::ICWT_MODE_RISE16);
   wire [3:0] psc_last = (mode == icwt_pkg::ICWT_MODE_RISE4) ?
                         `ICWT_PSC4_LAST : `ICWT_PSC16_LAST;
   wire psc_hit = pin_rise & (psc_reg == psc_last);
   logic edge_hit;

   always_comb begin
      unique case (mode)
         icwt_pkg::ICWT_MODE_EVERY_EDGE: edge_hit = pin_rise | pin_fall;
         icwt_pkg::ICWT_MODE_FALL: edge_hit = pin_fall;
         icwt_pkg::ICWT_MODE_RISE: edge_hit = pin_rise;
         icwt_pkg::ICWT_MODE_RISE4: edge_hit = psc_hit;
         icwt_pkg::ICWT_MODE_RISE16: edge_hit = psc_hit;
         icwt_pkg::ICWT_MODE_OFF: edge_hit = 1'b0;
         icwt_pkg::ICWT_MODE_DISABLED: edge_hit = 1'b0;
         icwt_pkg::ICWT_MODE_WAKE: edge_hit = 1'b0;
      endcase
   end

   wire cap_evt = run_ok & (casc_follow ? partner_cap_i : edge_hit);
   assign cap_o = cap_evt;

   // FIFO
   wire fifo_ready;
   wire fifo_valid;
   wire [15:0] fifo_data;
   wire bus_req = avs_read_i | avs_write_i;
   wire take = bus_req & ~ack_reg;
   wire [1:0] reg_sel = avs_address_i[3:2];
   wire addr_mapped = (avs_address_i[1:0] == 2'h0) &&
                      (reg_sel != 2'h3);
   wire buf_read = take & avs_read_i & addr_mapped &
                   (reg_sel == `ICWT_REG_BUFFER);
   wire push = cap_evt & fifo_ready;
   wire drop = cap_evt & ~fifo_ready;

   icwt_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(cap_evt),
      .in_ready_o(fifo_ready),
      .in_data_i(capture_counter_reg),
      .out_valid_o(fifo_valid),
      .out_ready_i(buf_read),
      .out_data_o(fifo_data)
   );

   assign buffer_not_empty_o = fifo_valid;

   // Interrupt pacing
   wire irq_fire = push &
                   ((mode == icwt_pkg::ICWT_MODE_EVERY_EDGE) ||
                    (irq_cnt_reg == captures_per_interrupt));

   // Register read view
   wire [15:0] ctrl1_view = (ctrl1_reg & `ICWT_CTRL1_WMASK) |
                            (16'(capture_overflow_flag_reg)
                             << `ICWT_OVF_BIT) |
                            (16'(fifo_valid) << `ICWT_BNE_BIT);
   wire [15:0] ctrl2_view = (ctrl2_reg & `ICWT_CTRL2_WMASK &
                             ~(16'h0001 << `ICWT_TRIG_STAT_BIT)) |
                            (16'(trigger_status_reg)
                             << `ICWT_TRIG_STAT_BIT);
   logic [15:0] read_mux;

   always_comb begin
      read_mux = 16'h0000;
      if (addr_mapped) begin
         unique case (reg_sel)
            `ICWT_REG_CTRL1: read_mux = ctrl1_view;
            `ICWT_REG_CTRL2: read_mux = ctrl2_view;
            `ICWT_REG_BUFFER: read_mux = fifo_valid ? fifo_data : 16'h0000;
            default: read_mux = 16'h0000;
         endcase
      end
   end

   // Byte-lane write merge
   wire [15:0] lane_mask = {{8{avs_byteenable_i[1]}},
                            {8{avs_byteenable_i[0]}}};
   wire commit = ack_reg & avs_write_i & addr_mapped;
   wire wr_ctrl1 = commit & (reg_sel == `ICWT_REG_CTRL1);
   wire wr_ctrl2 = commit & (reg_sel == `ICWT_REG_CTRL2);
   wire [15:0] wmask1 = lane_mask & `ICWT_CTRL1_WMASK;
   wire [15:0] wmask2 = lane_mask & `ICWT_CTRL2_WMASK;
   wire [15:0] ctrl1_new = (ctrl1_reg & ~wmask1) |
                           (avs_writedata_i[15:0] & wmask1);
   wire [15:0] ctrl2_new = (ctrl2_reg & ~wmask2) |
                           (avs_writedata_i[15:0] & wmask2);
   wire sw_trig_wr = wr_ctrl2 & avs_byteenable_i[0];
   wire sw_trig_val = avs_writedata_i[`ICWT_TRIG_STAT_BIT];

   assign avs_waitrequest_o = bus_req & ~ack_reg;
   assign avs_readdata_o = rdata_reg;
   assign cap_irq_o = cap_irq_reg;
   assign wake_irq_o = wake_irq_reg;

   // Bus handshake and read data
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= take;
         if (take & avs_read_i) rdata_reg <= {16'h0000, read_mux};
      end
   end

   // Control registers
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl1_reg <= `ICWT_CTRL1_RESET;
         ctrl2_reg <= `ICWT_CTRL2_RESET;
      end else begin
         if (wr_ctrl1) ctrl1_reg <= ctrl1_new;
         if (wr_ctrl2) ctrl2_reg <= ctrl2_new;
      end
   end

   // Trigger status: hardware set wins over a software clear
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trigger_status_reg <= 1'b0;
      end else if (hw_trigger) begin
         trigger_status_reg <= 1'b1;
      end else if (sw_trig_wr) begin
         trigger_status_reg <= sw_trig_val;
      end
   end

   // Overflow: set on a dropped capture, cleared when the capture mode is ICWT_MODE_OFF
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         capture_overflow_flag_reg <= 1'b0;
      end else if (drop) begin
         capture_overflow_flag_reg <= 1'b1;
      end else if (mode == icwt_pkg::ICWT_MODE_OFF) begin
         capture_overflow_flag_reg <= 1'b0;
      end
   end

   // Counter
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         capture_counter_reg <= 16'h0000;
      end else begin
         capture_counter_reg <= capture_counter_next;
      end
   end

   // Rising-edge prescaler
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         psc_reg <= 4'h0;
      end else if (!psc_mode || !run_ok) begin
         psc_reg <= 4'h0;
      end else if (pin_rise) begin
         psc_reg <= psc_hit ? 4'h0 : psc_reg + 4'h1;
      end
   end

   // Capture interrupt counter
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_cnt_reg <= 2'h0;
         cap_irq_reg <= 1'b0;
      end else begin
         cap_irq_reg <= irq_fire;
         if (!unit_on || irq_fire) begin
            irq_cnt_reg <= 2'h0;
         end else if (push) begin
            irq_cnt_reg <= irq_cnt_reg + 2'h1;
         end
      end
   end

   // Wake source in low-power states
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_irq_reg <= 1'b0;
      end else begin
         wake_irq_reg <= (mode == icwt_pkg::ICWT_MODE_WAKE) & pin_rise &
                         (cpu_sleep_i | cpu_idle_i);
      end
   end
endmodule : icwt_top

//--- icwt_pin_model.sv
// Pulse source standing on the capture input pin
`timescale 1ns/1ps
module icwt_pin_model (
   input wire logic ref_clk_i,
   output logic pin_o
);
   initial pin_o = 1'b0;
   // Each level is held gap clocks; the pin idles low
   task automatic pulses(input int n, input int gap);
      repeat (n) begin
         repeat (gap) @(posedge ref_clk_i);
         pin_o <= 1'b1;
         repeat (gap) @(posedge ref_clk_i);
         pin_o <= 1'b0;
      end
   endtask : pulses
endmodule : icwt_pin_model

//--- icwt_top_assertions.sv
// Port checks for the capture unit
`timescale 1ns/1ps
module icwt_top_assertions (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic cpu_idle_i,
   input wire logic cpu_sleep_i,
   input wire logic wrap_o,
   input wire logic clr_o,
   input wire logic cap_o,
   input wire logic cap_irq_o,
   input wire logic wake_irq_o,
   input wire logic buffer_not_empty_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   wire req = avs_read_i | avs_write_i;
   wire taken = req & avs_waitrequest_o;
   wire pop = taken & avs_read_i & (avs_address_i == 4'h8);
   chk_bus_answer:
   assert property ($rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not one cycle after request");
   chk_bus_idle:
   assert property (!req |-> !avs_waitrequest_o)
      else $error("waitrequest without request");
   chk_rdata_hold:
   assert property (!$past(taken & avs_read_i) |-> $stable(avs_readdata_o))
      else $error("read data moved without a read");
   chk_bne_rise:
   assert property ($rose(buffer_not_empty_o) |-> $past(cap_o))
      else $error("not-empty rose without a capture");
   chk_bne_fall:
   assert property ($fell(buffer_not_empty_o) |-> $past(pop))
      else $error("not-empty fell without a buffer read");
   chk_irq_cause:
   assert property (cap_irq_o |-> $past(cap_o))
      else $error("capture interrupt without a capture");
   chk_wrap_spacing:
   assert property (wrap_o |=> !wrap_o)
      else $error("counter wrapped on two cycles in a row");
   chk_wake_cause:
   assert property (wake_irq_o |-> $past(cpu_idle_i | cpu_sleep_i))
      else $error("wake interrupt while running");
endmodule : icwt_top_assertions
bind icwt_top icwt_top_assertions i_icwt_top_assertions (.ref_clk_i,
   .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
   .avs_waitrequest_o, .cpu_idle_i, .cpu_sleep_i, .wrap_o, .clr_o, .cap_o,
   .cap_irq_o, .wake_irq_o, .buffer_not_empty_o);

//--- icwt_top_test.sv
// Self-checking bench for the capture unit
`timescale 1ns/1ps
module icwt_top_test;
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic capture_input_pin_i;
   logic [4:0] tb_tick_i = 5'h0;
   logic [31:0] sync_evt_i = 32'h0;
   logic [31:0] sync_src_en_i = 32'h0;
   logic cpu_idle_i = 1'b0;
   logic cpu_sleep_i = 1'b0;
   logic sel_even = 1'b0;
   logic even_read = 1'b0;
   logic even_write = 1'b0;
   logic [31:0] even_rdata;
   logic even_wait;
   logic wrap_o, clr_o, cap_o, cap_irq_o, wake_irq_o, buffer_not_empty_o;
   int fail_count = 0;
   int check_count = 0;
   int cap_n = 0;
   int irq_n = 0;
   int wake_n = 0;
   int wrap_n = 0;
   logic [31:0] v [4];
   // Bus answer of whichever unit the bench currently addresses
   wire bus_wait = sel_even ? even_wait : avs_waitrequest_o;
   wire [31:0] bus_rdata = sel_even ? even_rdata : avs_readdata_o;
   icwt_top i_icwt_top (.ref_clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .capture_input_pin_i, .tb_tick_i, .sync_evt_i,
      .sync_src_en_i, .cpu_idle_i, .cpu_sleep_i, .partner_wrap_i(1'b0),
      .partner_clr_i(1'b0), .partner_cap_i(1'b0), .wrap_o, .clr_o, .cap_o,
      .cap_irq_o, .wake_irq_o, .buffer_not_empty_o);
   // High half of a cascaded pair, fed by the odd unit above
   icwt_top #(.IS_EVEN(1'b1)) i_icwt_top_even (.ref_clk_i, .arst_n_i,
      .avs_address_i, .avs_read_i(even_read), .avs_write_i(even_write),
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o(even_rdata),
      .avs_waitrequest_o(even_wait), .capture_input_pin_i(1'b0), .tb_tick_i,
      .sync_evt_i, .sync_src_en_i, .cpu_idle_i, .cpu_sleep_i,
      .partner_wrap_i(wrap_o), .partner_clr_i(clr_o), .partner_cap_i(cap_o),
      .wrap_o(), .clr_o(), .cap_o(), .cap_irq_o(), .wake_irq_o(),
      .buffer_not_empty_o());
   icwt_pin_model i_icwt_pin_model (.ref_clk_i, .pin_o(capture_input_pin_i));
   always #5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      if (cap_o === 1'b1) cap_n++;
      if (cap_irq_o === 1'b1) irq_n++;
      if (wake_irq_o === 1'b1) wake_n++;
      if (wrap_o === 1'b1) wrap_n++;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : wt
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [15:0] d, output logic [31:0] rd);
      avs_address_i <= a;
      avs_writedata_i <= {16'h0, d};
      avs_write_i <= w & !sel_even;
      avs_read_i <= !w & !sel_even;
      even_write <= w & sel_even;
      even_read <= !w & sel_even;
      do @(posedge ref_clk_i); while (bus_wait !== 1'b0);
      rd = bus_rdata;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      even_write <= 1'b0;
      even_read <= 1'b0;
      @(posedge ref_clk_i);
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 16'h0, x);
      check(x, exp);
   endtask : rdc
   task automatic pop(input int i);
      bus(1'b0, 4'h8, 16'h0, v[i]);
   endtask : pop
   task automatic drain();
      for (int i = 0; i < 4; i++) pop(i);
   endtask : drain
   task automatic pl(input int n, input int g);
      i_icwt_pin_model.pulses(n, g);
      wt(5);
   endtask : pl
   task automatic t_regs();
      rdc(4'h0, 32'h0);
      rdc(4'h4, 32'hd);
      avs_byteenable_i <= 4'h1;
      wr(4'h0, 16'hffff);
      rdc(4'h0, 32'h67);
      avs_byteenable_i <= 4'hf;
      wr(4'h0, 16'hffff);
      wr(4'hc, 16'h0);
      rdc(4'h0, 32'h3c67);
      rdc(4'hc, 32'h0);
      wr(4'h0, 16'h0);
      $display("regs done");
   endtask : t_regs
   task automatic t_free();
      sel_even = 1'b1;
      wr(4'h4, 16'h0100);
      wr(4'h0, 16'h1c03);
      sel_even = 1'b0;
      wr(4'h4, 16'h0100);
      wr(4'h0, 16'h1c03);
      pl(2, 6);
      rdc(4'h0, 32'h1c0b);
      pop(0);
      pop(1);
      check(v[1] - v[0], 32'd12);
      wrap_n = 0;
      i_icwt_pin_model.pulses(1, 3);
      wt(65534);
      pl(1, 3);
      pop(2);
      pop(3);
      check({16'h0, v[3][15:0] - v[2][15:0]}, 32'd4);
      check(wrap_n, 32'd1);
      rdc(4'h0, 32'h1c03);
      sel_even = 1'b1;
      drain();
      sel_even = 1'b0;
      check(v[2], 32'h0);
      check(v[3], 32'h1);
      $display("free done");
   endtask : t_free
   task automatic t_fifo();
      i_icwt_pin_model.pulses(1, 4);
      wt(100);
      pl(4, 4);
      rdc(4'h0, 32'h1c1b);
      drain();
      check(v[1] - v[0], 32'd108);
      check(v[3] - v[1], 32'd16);
      rdc(4'h8, 32'h0);
      rdc(4'h0, 32'h1c13);
      wr(4'h0, 16'h0);
      rdc(4'h0, 32'h0);
      $display("fifo done");
   endtask : t_fifo
   task automatic t_modes();
      int caps [7] = '{0, 32, 16, 16, 4, 1, 0};
      for (logic [3:0] m = 0; m < 7; m++) begin
         wr(4'h0, 16'h0);
         wr(4'h0, {13'h0380, m[2:0]});
         cap_n = 0;
         pl(16, 2);
         check(cap_n, caps[m]);
      end
      wr(4'h0, 16'h0);
      drain();
      $display("modes done");
   endtask : t_modes
   task automatic t_irq();
      logic [15:0] cfg [5] = '{16'h1c03, 16'h1c23, 16'h1c43, 16'h1c63,
         16'h1c61};
      int irqs [5] = '{4, 2, 1, 1, 4};
      for (int k = 0; k < 5; k++) begin
         wr(4'h0, 16'h0);
         wr(4'h0, cfg[k]);
         irq_n = 0;
         pl(k == 4 ? 2 : 4, 2);
         check(irq_n, irqs[k]);
         drain();
      end
      $display("irq done");
   endtask : t_irq
   task automatic t_idle();
      cpu_idle_i <= 1'b1;
      wr(4'h0, 16'h3c03);
      cap_n = 0;
      pl(2, 2);
      check(cap_n, 32'd0);
      wr(4'h0, 16'h1c03);
      pl(2, 2);
      check(cap_n, 32'd2);
      wr(4'h0, 16'h1c07);
      wake_n = 0;
      pl(1, 2);
      check(wake_n, 32'd1);
      cpu_idle_i <= 1'b0;
      pl(1, 2);
      check(wake_n, 32'd1);
      cpu_sleep_i <= 1'b1;
      pl(1, 2);
      check(wake_n, 32'd2);
      cpu_sleep_i <= 1'b0;
      check(cap_n, 32'd2);
      wr(4'h0, 16'h0);
      drain();
      $display("idle done");
   endtask : t_idle
   task automatic t_trig();
      wr(4'h4, 16'h0080);
      wr(4'h0, 16'h1c03);
      rdc(4'h4, 32'h80);
      pl(1, 2);
      check(buffer_not_empty_o, 32'h0);
      pop(0);
      check(v[0], 32'h0);
      wr(4'h4, 16'h00c0);
      pl(2, 3);
      pop(0);
      pop(1);
      check(v[1] - v[0], 32'd6);
      wr(4'h0, 16'h0);
      wr(4'h4, 16'h0081);
      wr(4'h0, 16'h1c03);
      pl(1, 2);
      check(buffer_not_empty_o, 32'h0);
      pop(0);
      check(v[0], 32'h0);
      sync_evt_i <= 32'h2;
      wt(1);
      sync_evt_i <= 32'h0;
      wt(2);
      rdc(4'h4, 32'hc1);
      $display("trig done");
   endtask : t_trig
   task automatic t_sync();
      wr(4'h0, 16'h0);
      wr(4'h4, 16'h0001);
      wr(4'h0, 16'h1c03);
      check(clr_o, 32'd1);
      pl(1, 2);
      check(buffer_not_empty_o, 32'h0);
      pop(0);
      check(v[0], 32'h0);
      sync_src_en_i <= 32'h2;
      wt(20);
      check(clr_o, 32'd0);
      sync_evt_i <= 32'h2;
      wt(1);
      check(clr_o, 32'd1);
      sync_evt_i <= 32'h0;
      pl(1, 2);
      pop(0);
      check(v[0] < 32'd8, 32'd1);
      wr(4'h4, 16'h0018);
      sync_src_en_i <= 32'h0100_0000;
      sync_evt_i <= 32'h0100_0000;
      wt(1);
      check(clr_o, 32'd0);
      sync_evt_i <= 32'h0;
      sync_src_en_i <= 32'h0;
      wr(4'h4, 16'h0);
      $display("sync done");
   endtask : t_sync
   task automatic t_tick();
      int idx [5] = '{2, 1, 3, 4, 0};
      for (int c = 0; c < 5; c++) begin
         wr(4'h0, 16'h0);
         wr(4'h0, {3'h0, c[2:0], 10'h003});
         pl(1, 2);
         for (int j = 0; j < 10; j++) begin
            tb_tick_i <= j[0] ? 5'h1 << idx[c] : ~(5'h1 << idx[c]);
            wt(1);
         end
         tb_tick_i <= 5'h0;
         pl(1, 2);
         pop(0);
         pop(1);
         check(v[1] - v[0], 32'd5);
      end
      $display("tick done");
   endtask : t_tick
   initial begin
      repeat (90000) @(posedge ref_clk_i);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      wt(4);
      arst_n_i <= 1'b1;
      wt(1);
      t_regs();
      t_free();
      t_fifo();
      t_modes();
      t_irq();
      t_idle();
      t_trig();
      t_sync();
      t_tick();
      tally_and_finish();
   end
endmodule : icwt_top_test
